/* src/rtcc_pkg.sv */
package rtcc_pkg;

    // Chain geometry
    localparam int PRE_W      = 16;
    localparam int ST0_W      = 10;
    localparam int ST1_W      = 6;
    localparam int ST2_W      = 6;
    localparam int ST3_W      = 10;
    localparam int CNT_W      = 32;
    localparam int N_REQ      = 5;
    localparam int DIV_A      = 32;
    localparam int DIV_B      = 8;
    localparam int SRC_SEL_W  = 2;

    // Reset values after power reset
    localparam logic [PRE_W-1:0] PRE_RST    = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST    = 32'h0000_0000;
    localparam logic [N_REQ-1:0] REQ_RST    = 5'h00;

    // Clock source selection codes
    typedef enum logic [SRC_SEL_W-1:0] {
        RTCC_SRC_INT0 = 2'b00,
        RTCC_SRC_INT1 = 2'b01,
        RTCC_SRC_EXT0 = 2'b10,
        RTCC_SRC_EXT1 = 2'b11
    } rtcc_src_t;

    // Software write strobes with data
    typedef struct packed {
        logic             pre_wr;
        logic [PRE_W-1:0] pre_val;
        logic             high_wr;
        logic [15:0]      high_val;
        logic             low_wr;
        logic [15:0]      low_val;
    } rtcc_wr_t;

    // Reload values for every stage
    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [ST0_W-1:0] s0;
        logic [ST1_W-1:0] s1;
        logic [ST2_W-1:0] s2;
        logic [ST3_W-1:0] s3;
    } rtcc_rel_t;

endpackage : rtcc_pkg

/* src/rtcc_stage.sv */
`timescale 1ns/1ps
`default_nettype none
// One reloadable up-counting stage
module rtcc_stage #(
    parameter int W = 10
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         cnt_en,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic [W-1:0] reload,
    output logic      [W-1:0] value,
    output logic              ovf
);
    logic [W-1:0] value_r;
    logic         at_top;

    assign at_top = &value_r;
    assign value  = value_r;
    assign ovf    = cnt_en && at_top && !load;

    // Count up, reload on overflow; software load wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            value_r <= '0;
        end else if (load) begin
            value_r <= load_val;
        end else if (cnt_en) begin
            value_r <= at_top ? reload : value_r + W'(1);
        end
    end

    chk_stage_up: assert property (@(posedge clk) disable iff (!arst_n)
        (cnt_en && !load && !at_top) |=> value_r == $past(value_r) + W'(1))
        else $error("stage did not increment");
    chk_stage_reload: assert property (@(posedge clk) disable iff (!arst_n)
        ovf |=> value_r == $past(reload))
        else $error("stage did not reload on overflow");
endmodule : rtcc_stage
`default_nettype wire

/* src/rtcc_chain.sv */
// Behaviour
// - Chain clock event picked from two internal or two external sources.
// - Divide-by-32 and divide-by-8 prescalers each bypassable on their own.
// - Reloadable 16-bit prescale timer feeds the counter stages.
// - 32-bit counter of 10,6,6,10-bit stages, read as high and low words.
// - Every stage counts up only.
// - Each stage can raise its own interrupt request.
// - All stage requests merge into one shared request line.
// - Only power reset clears the block; other resets leave it alone.
// - Prescale timer plus counter readable as one 48-bit up-counter.
// - Periodic tick from chain, independent of processor clock.
// - Alarm request when counter reaches a preset compare time.
`timescale 1ns/1ps
`default_nettype none
module rtcc_chain
    import rtcc_pkg::*;
#(
    parameter int N_SRC = 4
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [N_SRC-1:0] src_tick,
    input  wire rtcc_src_t        src_sel,
    input  wire logic             run,
    input  wire logic             div32_on,
    input  wire logic             div8_on,
    input  wire rtcc_wr_t         wr,
    input  wire rtcc_rel_t        rel,
    input  wire logic [N_REQ-1:0] req_en,
    input  wire logic [N_REQ-1:0] req_clr,
    input  wire logic             alarm_en,
    input  wire logic             alarm_clr,
    input  wire logic [CNT_W-1:0] alarm_time,
    output logic      [15:0]      count_high_word,
    output logic      [15:0]      count_low_word,
    output logic      [PRE_W-1:0] prescale_timer,
    output logic      [47:0]      count48,
    output logic      [N_REQ-1:0] req_flags,
    output logic                  alarm_flag,
    output logic                  tick,
    output logic                  node_req
);
    logic             src_d_r;
    logic             src_edge;
    logic [4:0]       div32_r;
    logic [2:0]       div8_r;
    logic             a_out;
    logic             b_out;
    logic [N_REQ:0]   carry;
    logic [N_REQ-1:0] ovf;
    logic [CNT_W-1:0] cnt;
    logic [PRE_W-1:0] pre_v;
    logic [N_REQ-1:0] flag_r;
    logic             alarm_r;
    logic             alarm_hit;
    logic             alarm_armed_r;
    logic             tick_r;
    logic             node_r;
    logic [15:0]      high_r;
    logic [15:0]      low_r;
    logic [PRE_W-1:0] pre_r;
    logic [31:0]      hw_load;

    // Source select; inputs are enables sampled here, so edge gives one pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_d_r <= 1'b0;
        end else begin
            src_d_r <= src_tick[src_sel];
        end
    end
    assign src_edge = run && src_tick[src_sel] && !src_d_r;

    // Prescalers; bypass passes the pulse straight on
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div32_r <= 5'h00;
            div8_r  <= 3'h0;
        end else begin
            if (src_edge && div32_on) begin
                div32_r <= div32_r + 5'h01;
            end
            if (a_out && div8_on) begin
                div8_r <= div8_r + 3'h1;
            end
        end
    end
    assign a_out = div32_on ? (src_edge && &div32_r) : src_edge;
    assign b_out = div8_on ? (a_out && &div8_r) : a_out;
    assign carry[0] = b_out;

    // Word writes split over the stage fields
    assign hw_load = {wr.high_val, wr.low_val};

    // Prescale timer then the four counter stages, each fed by previous overflow
    rtcc_stage #(.W(PRE_W)) u_pre (
        .clk(clk), .arst_n(arst_n), .cnt_en(carry[0]), .load(wr.pre_wr),
        .load_val(wr.pre_val), .reload(rel.pre), .value(pre_v), .ovf(ovf[0]));
    rtcc_stage #(.W(ST0_W)) u_s0 (
        .clk(clk), .arst_n(arst_n), .cnt_en(carry[1]), .load(wr.low_wr),
        .load_val(hw_load[9:0]), .reload(rel.s0), .value(cnt[9:0]), .ovf(ovf[1]));
    rtcc_stage #(.W(ST1_W)) u_s1 (
        .clk(clk), .arst_n(arst_n), .cnt_en(carry[2]), .load(wr.low_wr),
        .load_val(hw_load[15:10]), .reload(rel.s1), .value(cnt[15:10]), .ovf(ovf[2]));
    rtcc_stage #(.W(ST2_W)) u_s2 (
        .clk(clk), .arst_n(arst_n), .cnt_en(carry[3]), .load(wr.high_wr),
        .load_val(hw_load[21:16]), .reload(rel.s2), .value(cnt[21:16]), .ovf(ovf[3]));
    rtcc_stage #(.W(ST3_W)) u_s3 (
        .clk(clk), .arst_n(arst_n), .cnt_en(carry[4]), .load(wr.high_wr),
        .load_val(hw_load[31:22]), .reload(rel.s3), .value(cnt[31:22]), .ovf(ovf[4]));
    assign carry[N_REQ:1] = ovf;

    // Sticky request flags; a new overflow beats a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < N_REQ; gi++) begin : g_flag
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    flag_r[gi] <= REQ_RST[gi];
                end else if (ovf[gi]) begin
                    flag_r[gi] <= 1'b1;
                end else if (req_clr[gi]) begin
                    flag_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Alarm fires on arrival at the preset time; set beats a same-cycle clear
    assign alarm_hit = alarm_en && alarm_armed_r && (cnt == alarm_time);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_r <= 1'b0;
        end else if (alarm_hit) begin
            alarm_r <= 1'b1;
        end else if (alarm_clr) begin
            alarm_r <= 1'b0;
        end
    end

    // Armed only once the counter has left the alarm time, so one arrival
    // gives one alarm even while the counter stands still on that time
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_armed_r <= 1'b0;
        end else if (cnt != alarm_time) begin
            alarm_armed_r <= 1'b1;
        end else if (alarm_en) begin
            alarm_armed_r <= 1'b0; // Match consumed
        end
    end

    // Tick on prescale overflow, counted only in chain events, not clk rate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= ovf[0];
        end
    end

    // Shared node request from enabled flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            node_r <= 1'b0;
        end else begin
            node_r <= |(flag_r & req_en) || (alarm_r && alarm_en);
        end
    end

    // Registered views of the chain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_r <= CNT_RST[31:16];
            low_r  <= CNT_RST[15:0];
            pre_r  <= PRE_RST;
        end else begin
            high_r <= cnt[31:16];
            low_r  <= cnt[15:0];
            pre_r  <= pre_v;
        end
    end

    assign count_high_word = high_r;
    assign count_low_word  = low_r;
    assign prescale_timer  = pre_r;
    assign count48         = {high_r, low_r, pre_r};
    assign req_flags       = flag_r;
    assign alarm_flag      = alarm_r;
    assign tick            = tick_r;
    assign node_req        = node_r;

    chk_node_merge: assert property (@(posedge clk) disable iff (!arst_n)
        (|(flag_r & req_en)) |=> node_r)
        else $error("enabled flag not merged into node request");
    chk_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
        ovf[0] |=> flag_r[0])
        else $error("prescale overflow did not set flag");
    chk_pre_carry: assert property (@(posedge clk) disable iff (!arst_n)
        ovf[1] |-> ovf[0])
        else $error("stage counted without carry");
    chk_div_step: assert property (@(posedge clk) disable iff (!arst_n)
        (div32_on && src_edge) |=> div32_r == $past(div32_r) + 5'h01)
        else $error("divide-by-32 prescaler did not step");
    chk_alarm_set: assert property (@(posedge clk) disable iff (!arst_n)
        alarm_hit |=> alarm_r)
        else $error("alarm flag not set on arrival");
    chk_flag_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (req_clr[1] && !ovf[1]) |=> !flag_r[1])
        else $error("stage flag not cleared");
    chk_tick_follow: assert property (@(posedge clk) disable iff (!arst_n)
        ovf[0] |=> tick_r)
        else $error("tick missing after prescale overflow");
    chk_view_high: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> high_r == $past(cnt[31:16]))
        else $error("high word view stale");
    chk_alarm_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (alarm_clr && !alarm_en) |=> !alarm_r)
        else $error("alarm flag not cleared");
    chk_count48: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> count48 == {$past(cnt), $past(pre_v)})
        else $error("48-bit view misaligned");
endmodule : rtcc_chain
`default_nettype wire

/* tb/rtc_divider_timer_chain_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_divider_timer_chain_tb_top
    import rtcc_pkg::*;
;
    logic             clk;
    logic             arst_n;
    logic [3:0]       src_tick;
    rtcc_src_t        src_sel;
    logic             run;
    logic             div32_on;
    logic             div8_on;
    rtcc_wr_t         wr;
    rtcc_rel_t        rel;
    logic [N_REQ-1:0] req_en;
    logic [N_REQ-1:0] req_clr;
    logic             alarm_en;
    logic             alarm_clr;
    logic [CNT_W-1:0] alarm_time;
    logic [15:0]      count_high_word;
    logic [15:0]      count_low_word;
    logic [PRE_W-1:0] prescale_timer;
    logic [47:0]      count48;
    logic [N_REQ-1:0] req_flags;
    logic             alarm_flag;
    logic             tick;
    logic             node_req;
    int               errors;
    int               num_checks;

    rtcc_chain #(.N_SRC(4)) dut_u (
        .clk(clk), .arst_n(arst_n), .src_tick(src_tick), .src_sel(src_sel), .run(run),
        .div32_on(div32_on), .div8_on(div8_on), .wr(wr), .rel(rel), .req_en(req_en),
        .req_clr(req_clr), .alarm_en(alarm_en), .alarm_clr(alarm_clr),
        .alarm_time(alarm_time), .count_high_word(count_high_word),
        .count_low_word(count_low_word), .prescale_timer(prescale_timer),
        .count48(count48), .req_flags(req_flags), .alarm_flag(alarm_flag),
        .tick(tick), .node_req(node_req)
    );

    // Free running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // One compare for every kind of value, widened to 48 bits
    task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Rising edges on one source bit; settle time covers the view lag
    task automatic events(input int b, input int n);
        repeat (n) begin
            src_tick[b] = 1'b1;
            cyc(1);
            src_tick[b] = 1'b0;
            cyc(1);
        end
        cyc(3);
    endtask

    task automatic write_all(input logic [15:0] p, input logic [15:0] h, input logic [15:0] l);
        wr = '{1'b1, p, 1'b1, h, 1'b1, l};
        cyc(1);
        wr = '0;
        cyc(2);
    endtask

    // Clear strobe held one cycle so set-wins-over-clear never collides
    task automatic clear_flags();
        req_clr = 5'h1F;
        cyc(1);
        req_clr = 5'h00;
        cyc(2);
    endtask

    task automatic t_prescale();
        rel.pre = 16'hFFFD;
        write_all(16'hFFFD, 16'h0000, 16'h0000);
        events(0, 1);
        cmp("prescale_timer", 48'(16'hFFFE), 48'(prescale_timer));
        events(0, 2);
        cmp("count48", 48'h0000_0001_FFFD, count48);
        cmp("pre_flag", 48'(1'b1), 48'(req_flags[0]));
    endtask

    task automatic t_flags();
        req_en = 5'h00;
        cyc(2);
        cmp("node_req_masked", 48'(1'b0), 48'(node_req));
        req_en = 5'h01;
        cyc(2);
        cmp("node_req_on", 48'(1'b1), 48'(node_req));
        clear_flags();
        cmp("flags_cleared", 48'(5'h00), 48'(req_flags));
        cmp("node_req_off", 48'(1'b0), 48'(node_req));
        req_en = 5'h1F;
    endtask

    // Every overflow of an all-ones prescaler steps the counter once
    task automatic t_select();
        rel.pre = 16'hFFFF;
        write_all(16'hFFFF, 16'h0000, 16'h0000);
        for (int s = 0; s < 4; s++) begin
            src_sel = rtcc_src_t'(s);
            cyc(2);
            events((s + 1) % 4, 1);
            cmp("other_source", 48'(s), 48'({count_high_word, count_low_word}));
            // Tick is a one-cycle pulse right after the prescale overflow
            src_tick[s] = 1'b1;
            cyc(1);
            cmp("tick_pulse", 48'(1'b1), 48'(tick));
            src_tick[s] = 1'b0;
            cyc(1);
            cmp("tick_end", 48'(1'b0), 48'(tick));
            cyc(3);
            cmp("chosen_source", 48'(s + 1), 48'({count_high_word, count_low_word}));
        end
        src_sel = RTCC_SRC_INT0;
        // Chain halted: a source edge must not step anything
        run = 1'b0;
        events(0, 1);
        cmp("run_off", 48'h4, 48'({count_high_word, count_low_word}));
        run = 1'b1;
    endtask

    // Any run of N events through an N:1 divider gives exactly one step
    task automatic t_div();
        div32_on = 1'b1;
        events(0, 32);
        cmp("div32", 48'h5, 48'({count_high_word, count_low_word}));
        div32_on = 1'b0;
        div8_on  = 1'b1;
        events(0, 8);
        cmp("div8", 48'h6, 48'({count_high_word, count_low_word}));
        div32_on = 1'b1;
        events(0, 256);
        cmp("div256", 48'h7, 48'({count_high_word, count_low_word}));
        div32_on = 1'b0;
        div8_on  = 1'b0;
    endtask

    task automatic t_cascade();
        write_all(16'hFFFF, 16'h0000, 16'hFFFF);
        clear_flags();
        events(0, 1);
        cmp("low_carry", 48'h0001_0000, 48'({count_high_word, count_low_word}));
        cmp("low_flags", 48'(5'h07), 48'(req_flags));
        write_all(16'hFFFF, 16'hFFFF, 16'hFFFF);
        clear_flags();
        events(0, 1);
        cmp("full_wrap", 48'h0000_FFFF, count48);
        cmp("all_flags", 48'(5'h1F), 48'(req_flags));
    endtask

    task automatic t_alarm();
        write_all(16'hFFFF, 16'h0000, 16'h0010);
        alarm_time = 32'h0000_0012;
        alarm_en   = 1'b1;
        cyc(2);
        events(0, 1);
        cmp("alarm_early", 48'(1'b0), 48'(alarm_flag));
        events(0, 1);
        cmp("alarm_hit", 48'(1'b1), 48'(alarm_flag));
        alarm_clr = 1'b1;
        cyc(1);
        alarm_clr = 1'b0;
        cyc(2);
        cmp("alarm_clr", 48'(1'b0), 48'(alarm_flag));
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Whole run is well under a thousand cycles; this limit leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end

    initial begin
        errors = 0; num_checks = 0; arst_n = 1'b0; src_tick = 4'h0; src_sel = RTCC_SRC_INT0;
        run = 1'b1; div32_on = 1'b0; div8_on = 1'b0; wr = '0; rel = '0; req_en = 5'h1F;
        req_clr = 5'h00; alarm_en = 1'b0; alarm_clr = 1'b0; alarm_time = 32'h0000_0000;
        cyc(5);
        arst_n = 1'b1;
        cyc(2);
        cmp("count48_reset", 48'h0, count48);
        t_prescale();
        t_flags();
        t_select();
        t_div();
        t_cascade();
        t_alarm();
        // Power reset in mid-run must clear everything
        arst_n = 1'b0;
        cyc(2);
        cmp("count48_por", 48'h0, count48);
        cmp("flags_por", 48'(5'h00), 48'(req_flags));
        arst_n = 1'b1;
        cyc(2);
        summarize();
    end
endmodule // rtc_divider_timer_chain_tb_top
`default_nettype wire
